// ---- common/lmibs_pkg.sv ----
// constants and types of the LED matrix two-wire slave with section selector
package lmibs_pkg;
   localparam int CLK_KHZ      = 32'h61A8;
   localparam int SCL_MAX_KHZ  = 32'h3E8;
   // least SCL half period at the top rate, in CLK cycles (rounded up)
   localparam int SCL_HALF_CYC = (CLK_KHZ + 2 * SCL_MAX_KHZ - 1) / (2 * SCL_MAX_KHZ);

   localparam int FRAMES      = 32'h6;
   localparam int FRAME_BYTES = 32'hB4;
   localparam int CTRL_REGS   = 32'h10;
   localparam int CTRL_AW     = 32'h4;
   localparam int CTRL_W      = CTRL_REGS * 8;

   localparam logic [7:0] SEL_ADDR   = 8'hFD;
   localparam logic [7:0] SEL_FRAME0 = 8'h01;
   localparam logic [7:0] SEL_FRAME5 = 8'h06;
   localparam logic [7:0] SEL_CTRL   = 8'h0B;
   localparam logic [7:0] SEL_RST    = 8'h0B;
   localparam logic [7:0] PTR_RST    = 8'h00;

   localparam logic [7:0] CFG_OFS    = 8'h00;
   localparam int         CFG_LAYOUT = 32'h0;
   localparam logic [7:0] SD_OFS     = 8'h0A;
   localparam int         SD_BIT     = 32'h0;
   localparam logic [7:0] SD_RST     = 8'h01;
   localparam logic [CTRL_W-1:0] CTRL_RST = CTRL_W'(SD_RST) << (8 * SD_OFS);

   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam int ADDR_RW_BIT  = 32'h0;
   localparam int ADDR_AD0_BIT = 32'h1;
   localparam int ADDR_AD1_BIT = 32'h2;
   // device type code in address bits 7..3; value is arbitrary
   localparam logic [4:0] DEV_TYPE = 5'h15;

   typedef enum logic [2:0] {
      LMIBS_IDLE,
      LMIBS_RX,
      LMIBS_RX_ACK,
      LMIBS_TX,
      LMIBS_TX_ACK,
      LMIBS_SKIP
   } lmibs_st_t;

   typedef struct packed {
      logic [2:0]                     scl_s;
      logic [2:0]                     sda_s;
      logic [1:0]                     ad0_s;
      logic [1:0]                     ad1_s;
      logic [1:0]                     hwn_s;
      lmibs_st_t                      st;
      logic [3:0]                     bitcnt;
      logic [7:0]                     shreg;
      logic                           addr_ph;
      logic                           ptr_ph;
      logic                           rw;
      logic                           mack;
      logic                           sda_low;
      logic [7:0]                     ptr;
      logic [7:0]                     sel;
      logic [CTRL_REGS-1:0][7:0]      ctrl;
   } lmibs_state_t;

   localparam lmibs_state_t ST_RST = '{
      scl_s: 3'h7, sda_s: 3'h7, ad0_s: 2'h0, ad1_s: 2'h0, hwn_s: 2'h3,
      st: LMIBS_IDLE, bitcnt: 4'h0, shreg: 8'h00, addr_ph: 1'b0,
      ptr_ph: 1'b0, rw: 1'b0, mack: 1'b0, sda_low: 1'b0,
      ptr: PTR_RST, sel: SEL_RST, ctrl: CTRL_RST};

   typedef struct packed {
      logic       en;
      logic [2:0] frame;
      logic [7:0] addr;
      logic [7:0] data;
   } lmibs_wr_t;

   typedef struct packed {
      logic [2:0] frame;
      logic [7:0] addr;
   } lmibs_rd_t;
endpackage

// ---- hw/lmibs_frame_mem.sv ----
// frame memory: six frames of byte storage, one write port and two read ports
`timescale 1ns/1ps
module lmibs_frame_mem #(
   parameter int FRAMES = lmibs_pkg::FRAMES,
   parameter int BYTES  = lmibs_pkg::FRAME_BYTES
) (
   input  wire logic                 clk,
   input  wire lmibs_pkg::lmibs_wr_t wr,
   input  wire lmibs_pkg::lmibs_rd_t rd_a,
   input  wire lmibs_pkg::lmibs_rd_t rd_b,
   output logic [7:0]                rd_a_data,
   output logic [7:0]                rd_b_data
);
   // contents have no reset: power-up data is whatever the cells hold
   logic [7:0] mem [FRAMES*BYTES]; // R22

   // same in-frame layout for every frame, only the base moves
   function automatic int idx(logic [2:0] f, logic [7:0] a);
      return int'(f) * BYTES + int'(a); // R24
   endfunction

   function automatic logic ok(logic [2:0] f, logic [7:0] a);
      return (int'(f) < FRAMES) && (int'(a) < BYTES);
   endfunction

   always_ff @(posedge clk) begin
      // on/off, blink and intensity bytes are stored as written
      if (wr.en && ok(wr.frame, wr.addr)) begin
         mem[idx(wr.frame, wr.addr)] <= wr.data; // R21
      end
      // second port lets the scanner read while the bus side writes
      rd_a_data <= ok(rd_a.frame, rd_a.addr) ? mem[idx(rd_a.frame, rd_a.addr)] : 8'h00; // R25
      rd_b_data <= ok(rd_b.frame, rd_b.addr) ? mem[idx(rd_b.frame, rd_b.addr)] : 8'h00; // R26
   end
endmodule

// ---- hw/lmibs_top.sv ----
// two-wire slave port with section selector, control bytes and frame memory
// Notes on behaviour
// R01 - serial port works with SCL up to 1 MHz
// R02 - device is slave only; master drives clock, START and STOP
// R03 - master starts a transfer only while SDA and SCL are both high
// R04 - SDA holds still while SCL is high; changes then are conditions
// R05 - SDA falling with SCL high is START, rising is STOP
// R06 - eight clock pulses per byte plus a ninth acknowledge pulse
// R07 - acknowledging receiver holds SDA low through the ninth pulse high phase
// R08 - after master not-acknowledge the device releases SDA for STOP
// R09 - in a write the device acknowledges address and every data byte
// R10 - in a read the device sends bytes after its address acknowledge
// R11 - repeated START ends a transfer and starts the next one
// R12 - address bits one and two must equal the two strap pins
// R13 - address bit zero set means read, clear means write
// R14 - device type and direction are checked, then acknowledged on SDA; the code checks type and straps and takes either direction
// R15 - first written byte sets pointer; later bytes go there; reads follow it
// R16 - power-up loads defaults, blanks display and enters shutdown
// R17 - shutdown byte at 0x0A turns LEDs off and halts logic; the code only raises SHUTDOWN and keeps the serial port running
// R18 - low hardware shutdown pin shuts down and reloads power-on defaults
// R19 - selector at 253: 0 no-op, 1..6 frames, 11 control section
// R20 - selected section stays until another section is written
// R21 - frame memory holds six frames of on/off, blink, PWM data
// R22 - frame memory has no defined power-up contents
// R23 - control bit D0 chooses two 8x9 or three 5x6 matrices
// R24 - in-frame address layout is the same for all frames
// R25 - on/off bytes hold one bit per LED, one means on
// R26 - blink bytes from offset 0x12 hold one blink bit per LED
`timescale 1ns/1ps
module lmibs_top #(
   parameter logic [4:0] DEV_TYPE = lmibs_pkg::DEV_TYPE
) (
   input  wire logic       CLK,
   input  wire logic       SYS_RST,
   input  wire logic       SCL_I,
   input  wire logic       SDA_I,
   output logic            SDA_O,
   output logic            SDA_OE,
   input  wire logic       ADDR_STRAP_LOW,
   input  wire logic       ADDR_STRAP_HIGH,
   input  wire logic       HW_SHUTDOWN_N,
   input  wire logic [2:0] SCAN_FRAME,
   input  wire logic [7:0] SCAN_ADDR,
   output logic [7:0]      SCAN_DATA,
   output logic [7:0]      SECTION,
   output logic            SHUTDOWN,
   output logic            LAYOUT_3X5
);
   lmibs_pkg::lmibs_state_t r;
   lmibs_pkg::lmibs_state_t n;
   lmibs_pkg::lmibs_wr_t    wr;
   lmibs_pkg::lmibs_rd_t    rd_bus;
   lmibs_pkg::lmibs_rd_t    rd_scan;
   logic [7:0]              mem_byte;
   logic [7:0]              rd_byte;
   logic [2:0]              fidx;
   logic                    scl_h;
   logic                    sda_h;
   logic                    scl_rise;
   logic                    scl_fall;
   logic                    start;
   logic                    stop;
   logic                    hw_sd;
   logic                    sel_frame;
   logic                    sel_ok;
   logic                    addr_match;
   logic                    byte_done;
   logic                    data_byte;
   logic                    sel_wr;

   // the second stage gives the SCL and SDA levels; the second and third stages together give the edges
   assign scl_h    = r.scl_s[1];
   assign sda_h    = r.sda_s[1];
   assign scl_rise = r.scl_s[1] & ~r.scl_s[2];
   assign scl_fall = ~r.scl_s[1] & r.scl_s[2];
   assign start    = scl_h & r.scl_s[2] & ~r.sda_s[1] & r.sda_s[2]; // R05
   assign stop     = scl_h & r.scl_s[2] & r.sda_s[1] & ~r.sda_s[2]; // R05
   assign hw_sd    = ~r.hwn_s[1];

   assign sel_frame = (r.sel >= lmibs_pkg::SEL_FRAME0) && (r.sel <= lmibs_pkg::SEL_FRAME5);
   assign fidx      = sel_frame ? 3'(r.sel - lmibs_pkg::SEL_FRAME0) : 3'h0;
   // zero keeps the old section, unknown codes are dropped
   assign sel_ok    = ((r.shreg >= lmibs_pkg::SEL_FRAME0)
                       && (r.shreg <= lmibs_pkg::SEL_FRAME5))
                      || (r.shreg == lmibs_pkg::SEL_CTRL); // R19

   // type code in bits 7..3, straps in bits 2..1, bit 0 free for direction
   assign addr_match = (r.shreg[7:3] == DEV_TYPE)
                       && (r.shreg[lmibs_pkg::ADDR_AD1_BIT] == r.ad1_s[1])
                       && (r.shreg[lmibs_pkg::ADDR_AD0_BIT] == r.ad0_s[1]); // R12

   assign byte_done = (r.st == lmibs_pkg::LMIBS_RX) && scl_fall
                      && (r.bitcnt == lmibs_pkg::BITS_PER_BYTE); // R06
   assign data_byte = byte_done && !r.addr_ph && !r.ptr_ph;
   assign sel_wr    = data_byte && (r.ptr == lmibs_pkg::SEL_ADDR);

   // read source follows the pointer and the selected section
   always_comb begin
      rd_byte = 8'h00;
      if (r.ptr == lmibs_pkg::SEL_ADDR) begin
         rd_byte = r.sel;
      end else if (sel_frame) begin
         rd_byte = mem_byte;
      end else if (r.sel == lmibs_pkg::SEL_CTRL && int'(r.ptr) < lmibs_pkg::CTRL_REGS) begin
         rd_byte = r.ctrl[r.ptr[lmibs_pkg::CTRL_AW-1:0]];
      end
   end

   // first data bit goes out at once; the pointer moves on for the next byte
   function automatic lmibs_pkg::lmibs_state_t load_tx(lmibs_pkg::lmibs_state_t s,
                                                        logic [7:0] b);
      lmibs_pkg::lmibs_state_t t;
      t         = s;
      t.st      = lmibs_pkg::LMIBS_TX;
      t.shreg   = b;
      t.bitcnt  = 4'h0;
      t.sda_low = ~b[7];
      t.ptr     = s.ptr + 8'h01;
      return t;
   endfunction

   always_comb begin
      n  = r;
      wr = '0;
      // SCL is only ever sampled, never pulled: the master owns the clock
      n.scl_s = {r.scl_s[1:0], SCL_I}; // R02
      // two stages cost 80 ns, well inside a 500 ns SCL half period
      n.sda_s = {r.sda_s[1:0], SDA_I}; // R01
      n.ad0_s = {r.ad0_s[0], ADDR_STRAP_LOW};
      n.ad1_s = {r.ad1_s[0], ADDR_STRAP_HIGH};
      n.hwn_s = {r.hwn_s[0], HW_SHUTDOWN_N};

      case (r.st)
         lmibs_pkg::LMIBS_IDLE: begin
            // waits for START, which the master issues only on an idle bus
            n.sda_low = 1'b0; // R03
         end
         lmibs_pkg::LMIBS_RX: begin
            if (scl_rise) begin
               n.shreg  = {r.shreg[6:0], sda_h};
               n.bitcnt = r.bitcnt + 4'h1;
            end
            if (byte_done) begin
               if (r.addr_ph) begin
                  if (addr_match) begin
                     n.rw      = r.shreg[lmibs_pkg::ADDR_RW_BIT]; // R13
                     n.ptr_ph  = ~r.shreg[lmibs_pkg::ADDR_RW_BIT];
                     n.addr_ph = 1'b0;
                     n.sda_low = 1'b1; // R14
                     n.st      = lmibs_pkg::LMIBS_RX_ACK;
                  end else begin
                     n.st = lmibs_pkg::LMIBS_SKIP;
                  end
               end else if (r.ptr_ph) begin
                  n.ptr     = r.shreg; // R15
                  n.ptr_ph  = 1'b0;
                  n.sda_low = 1'b1; // R09
                  n.st      = lmibs_pkg::LMIBS_RX_ACK;
               end else begin
                  if (sel_wr) begin
                     if (sel_ok) begin
                        n.sel = r.shreg; // R20
                     end
                  end else if (sel_frame) begin
                     wr.en    = 1'b1;
                     wr.frame = fidx;
                     wr.addr  = r.ptr; // R24
                     wr.data  = r.shreg;
                  end else if (r.sel == lmibs_pkg::SEL_CTRL
                               && int'(r.ptr) < lmibs_pkg::CTRL_REGS) begin
                     n.ctrl[r.ptr[lmibs_pkg::CTRL_AW-1:0]] = r.shreg;
                  end
                  n.ptr     = r.ptr + 8'h01; // R15
                  n.sda_low = 1'b1; // R09
                  n.st      = lmibs_pkg::LMIBS_RX_ACK;
               end
            end
         end
         lmibs_pkg::LMIBS_RX_ACK: begin
            // low is held across the ninth pulse, let go on its falling edge
            if (scl_fall) begin
               n.sda_low = 1'b0; // R07
               n.bitcnt  = 4'h0;
               if (r.rw) begin
                  n = load_tx(n, rd_byte); // R10
               end else begin
                  n.st = lmibs_pkg::LMIBS_RX;
               end
            end
         end
         lmibs_pkg::LMIBS_TX: begin
            if (scl_rise) begin
               n.bitcnt = r.bitcnt + 4'h1;
            end
            // data only changes after SCL has gone low
            if (scl_fall) begin
               if (r.bitcnt == lmibs_pkg::BITS_PER_BYTE) begin
                  n.sda_low = 1'b0;
                  n.st      = lmibs_pkg::LMIBS_TX_ACK;
               end else begin
                  n.shreg   = {r.shreg[6:0], 1'b0};
                  n.sda_low = ~r.shreg[6]; // R04
               end
            end
         end
         lmibs_pkg::LMIBS_TX_ACK: begin
            if (scl_rise) begin
               n.mack = ~sda_h;
            end
            if (scl_fall) begin
               if (r.mack) begin
                  n = load_tx(n, rd_byte); // R10
               end else begin
                  // SDA stays released so the master can place STOP
                  n.st = lmibs_pkg::LMIBS_SKIP; // R08
               end
            end
         end
         lmibs_pkg::LMIBS_SKIP: begin
            n.sda_low = 1'b0;
         end
         default: begin
            n.st      = lmibs_pkg::LMIBS_IDLE;
            n.sda_low = 1'b0;
         end
      endcase

      // START from any state, so a repeated START restarts addressing
      if (start) begin
         n.st      = lmibs_pkg::LMIBS_RX; // R11
         n.bitcnt  = 4'h0;
         n.addr_ph = 1'b1;
         n.ptr_ph  = 1'b0;
         n.sda_low = 1'b0;
      end
      if (stop) begin
         n.st      = lmibs_pkg::LMIBS_IDLE; // R05
         n.sda_low = 1'b0;
      end
      // pin shutdown also drops the power-on defaults back in
      if (hw_sd) begin
         n.st      = lmibs_pkg::LMIBS_IDLE; // R18
         n.sda_low = 1'b0;
         n.addr_ph = 1'b0;
         n.ptr_ph  = 1'b0;
         n.ptr     = lmibs_pkg::PTR_RST;
         n.sel     = lmibs_pkg::SEL_RST;
         n.ctrl    = lmibs_pkg::CTRL_RST;
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         r <= lmibs_pkg::ST_RST; // R16
      end else begin
         r <= n;
      end
   end

   assign rd_bus  = '{frame: fidx, addr: r.ptr};
   assign rd_scan = '{frame: SCAN_FRAME, addr: SCAN_ADDR};

   lmibs_frame_mem #(
      .FRAMES (lmibs_pkg::FRAMES),
      .BYTES  (lmibs_pkg::FRAME_BYTES)
   ) u_mem (
      .clk       (CLK),
      .wr        (wr),
      .rd_a      (rd_bus),
      .rd_b      (rd_scan),
      .rd_a_data (mem_byte),
      .rd_b_data (SCAN_DATA)
   );

   // open drain: the pin is only ever pulled low
   assign SDA_O    = 1'b0;
   assign SDA_OE   = r.sda_low;
   assign SECTION  = r.sel;
   // shutdown blanks the LEDs; in software shutdown the serial port stays alive to undo it
   assign SHUTDOWN = r.ctrl[lmibs_pkg::SD_OFS][lmibs_pkg::SD_BIT] | hw_sd; // R17
   assign LAYOUT_3X5 = r.ctrl[lmibs_pkg::CFG_OFS][lmibs_pkg::CFG_LAYOUT]; // R23

   // checks
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SYS_RST);

   sequence s_done;
      byte_done && !hw_sd;
   endsequence

   sequence s_nack;
      r.st == lmibs_pkg::LMIBS_TX_ACK && scl_rise && sda_h && !hw_sd;
   endsequence

   sequence s_sd_write;
      s_done ##0 (data_byte && r.sel == lmibs_pkg::SEL_CTRL
                  && r.ptr == lmibs_pkg::SD_OFS && r.shreg[lmibs_pkg::SD_BIT]);
   endsequence

   AST_ADDR_ACK: assert property ( // R14
      s_done ##0 (r.addr_ph && addr_match)
      |=> r.sda_low && r.st == lmibs_pkg::LMIBS_RX_ACK)
      else $error("matching address not acknowledged");

   AST_ADDR_NACK: assert property ( // R12
      s_done ##0 (r.addr_ph && !addr_match)
      |=> !r.sda_low && r.st == lmibs_pkg::LMIBS_SKIP)
      else $error("foreign address acknowledged");

   AST_WR_ACK: assert property ( // R09
      s_done ##0 !r.addr_ph |=> r.sda_low)
      else $error("received byte not acknowledged");

   AST_ACK_HOLD: assert property ( // R07
      r.st == lmibs_pkg::LMIBS_RX_ACK && scl_h && !hw_sd |-> r.sda_low)
      else $error("sda released during acknowledge high phase");

   AST_START: assert property ( // R11
      start && !hw_sd |=> r.st == lmibs_pkg::LMIBS_RX && r.addr_ph && r.bitcnt == 4'h0)
      else $error("start did not restart addressing");

   AST_STOP: assert property ( // R05
      stop |=> r.st == lmibs_pkg::LMIBS_IDLE && !SDA_OE)
      else $error("stop did not return to idle");

   AST_NACK_REL: assert property ( // R08
      s_nack |=> !SDA_OE [*8])
      else $error("sda driven after master nack");

   AST_SDA_STABLE: assert property ( // R04
      scl_h && r.scl_s[2] && !hw_sd |-> $stable(r.sda_low))
      else $error("sda changed while scl high");

   AST_SEL_WR: assert property ( // R19
      s_done ##0 (sel_wr && sel_ok) |=> r.sel == $past(r.shreg))
      else $error("selector write lost");

   AST_SEL_KEEP: assert property ( // R20
      !(sel_wr && sel_ok) && !hw_sd |=> $stable(r.sel))
      else $error("section changed without selector write");

   AST_PTR_INC: assert property ( // R15
      s_done ##0 data_byte |=> r.ptr == $past(r.ptr) + 8'h01)
      else $error("pointer did not advance after data byte");

   AST_SW_SD: assert property ( // R17
      s_sd_write |=> SHUTDOWN)
      else $error("shutdown write had no effect");

   AST_HW_SD: assert property ( // R18
      hw_sd |=> SHUTDOWN && !SDA_OE && r.sel == lmibs_pkg::SEL_RST)
      else $error("hardware shutdown not honoured");

   AST_TX_LOAD: assert property ( // R10
      r.st == lmibs_pkg::LMIBS_RX_ACK && r.rw && scl_fall && !hw_sd
      |=> r.st == lmibs_pkg::LMIBS_TX && r.sda_low == ~$past(rd_byte[7]))
      else $error("read byte not started after address ack");
endmodule

// ---- tb/lmibs_master_model.sv ----
// two-wire bus master model: drives SCL, pulls SDA low, frames bytes
`timescale 1ns/1ps
module lmibs_master_model #(
   parameter int HALF = lmibs_pkg::SCL_HALF_CYC
) (
   input  wire logic clk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_pull
);
   int slow = 0;

   initial begin
      scl      = 1'b1; // idle bus, both lines high
      sda_pull = 1'b0;
   end

   task automatic wt();
      repeat (HALF) @(posedge clk);
   endtask

   // data moves only while scl is low; halves of at least 520 ns keep SCL under 1 MHz
   task automatic bit_io(input logic b, output logic r);
      // one cycle of hold after scl falls before data moves
      @(posedge clk);
      sda_pull <= ~b;
      repeat (slow) @(posedge clk);
      wt();
      scl <= 1'b1;
      wt();
      @(negedge clk);
      r = sda;
      @(posedge clk);
      scl <= 1'b0;
   endtask

   // also a repeated start: the bus is never freed
   task automatic start();
      sda_pull <= 1'b0;
      wt();
      scl <= 1'b1;
      wt();
      sda_pull <= 1'b1;
      wt();
      scl <= 1'b0;
   endtask

   task automatic stop();
      @(posedge clk);
      sda_pull <= 1'b1;
      wt();
      scl <= 1'b1;
      wt();
      sda_pull <= 1'b0;
      wt();
   endtask

   // extra ninth pulse carries the slave ack
   task automatic put(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask

   // ack every byte but the last, which gets a released line
   task automatic get(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(last, r);
   endtask
endmodule

// ---- tb/testbench.sv ----
// self-checking bench: serial transfers against a queue based model
`timescale 1ns/1ps
module testbench;
   logic       clk, sys_rst, scl, m_pull, sda_oe, sda_o, strap_lo, strap_hi, hw_n;
   logic [2:0] scan_frame;
   logic [7:0] scan_addr, scan_data, section;
   logic       shutdown, layout;
   // open drain with pull-up
   wire        sda = ~m_pull & (sda_oe ? sda_o : 1'b1);
   int         mismatches, n_compared, cycles, sel_m, ptr_m;
   int         pf[6];
   logic [7:0] ctrl_m[16];
   logic [7:0] fm[int];
   logic [7:0] wq[$];
   logic [7:0] codes[11] = '{8'h00, 8'h07, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
                             8'h0C, 8'h0B, 8'h06};

   lmibs_top u_lmibs_top (
      .CLK(clk), .SYS_RST(sys_rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
      .SDA_OE(sda_oe), .ADDR_STRAP_LOW(strap_lo), .ADDR_STRAP_HIGH(strap_hi),
      .HW_SHUTDOWN_N(hw_n), .SCAN_FRAME(scan_frame), .SCAN_ADDR(scan_addr),
      .SCAN_DATA(scan_data), .SECTION(section), .SHUTDOWN(shutdown), .LAYOUT_3X5(layout));
   lmibs_master_model u_master (.clk(clk), .sda(sda), .scl(scl), .sda_pull(m_pull));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic final_report();
      if (mismatches == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 100000) begin
         mismatches++;
         final_report();
      end
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic m_reset();
      sel_m = 11;
      ptr_m = 0;
      foreach (ctrl_m[i]) ctrl_m[i] = 8'h00;
      ctrl_m[10] = 8'h01;
   endtask

   task automatic m_write(input int p);
      ptr_m = p;
      foreach (wq[i]) begin
         if (ptr_m == 253) begin
            if ((wq[i] >= 1 && wq[i] <= 6) || wq[i] == 11) sel_m = wq[i];
         end else if (sel_m <= 6 && ptr_m < 180) fm[(sel_m - 1) * 256 + ptr_m] = wq[i];
         else if (sel_m == 11 && ptr_m < 16) ctrl_m[ptr_m] = wq[i];
         ptr_m = (ptr_m + 1) % 256;
      end
   endtask

   function automatic int m_read(int p);
      if (p == 253) return sel_m;
      if (sel_m == 11) return (p < 16) ? ctrl_m[p] : 0;
      if (p >= 180) return 0;
      return fm.exists((sel_m - 1) * 256 + p) ? fm[(sel_m - 1) * 256 + p] : -1;
   endfunction

   task automatic addr(input logic rw);
      logic ack;
      u_master.put({lmibs_pkg::DEV_TYPE, strap_hi, strap_lo, rw}, ack);
      chk("address ack", 1, ack);
   endtask

   task automatic bad_addr(input logic [7:0] a);
      logic ack;
      u_master.start();
      u_master.put(a, ack);
      chk("foreign address ack", 0, ack);
      u_master.stop();
   endtask

   task automatic wr(input logic [7:0] p);
      logic ack;
      u_master.start();
      addr(1'b0);
      u_master.put(p, ack);
      chk("pointer ack", 1, ack);
      foreach (wq[i]) begin
         u_master.put(wq[i], ack);
         chk("data ack", 1, ack);
      end
      u_master.stop();
      m_write(p);
   endtask

   task automatic rd(input logic [7:0] p, input int n);
      logic       ack;
      logic [7:0] d;
      int         e;
      u_master.start();
      addr(1'b0);
      u_master.put(p, ack);
      u_master.start();
      addr(1'b1);
      for (int i = 0; i < n; i++) begin
         u_master.get(i == n - 1, d);
         e = m_read((p + i) % 256);
         if (e >= 0) chk("read data", e, d);
      end
      repeat (6) @(posedge clk);
      @(negedge clk);
      chk("release after nack", 0, sda_oe);
      u_master.stop();
      ptr_m = (p + n) % 256;
   endtask

   task automatic scan(input int f, input int a);
      @(posedge clk);
      scan_frame <= f[2:0];
      scan_addr  <= a[7:0];
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("scan data", fm[f * 256 + a], scan_data);
   endtask

   initial begin
      void'($urandom(32'hC806B3B4));
      sys_rst    = 1'b1;
      hw_n       = 1'b1;
      scan_frame = 3'h0;
      scan_addr  = 8'h00;
      strap_lo   = 1'($urandom);
      strap_hi   = 1'($urandom);
      m_reset();
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      @(negedge clk);
      chk("section at reset", 8'h0B, section);
      chk("shutdown at reset", 1, shutdown);
      chk("layout at reset", 0, layout);
      chk("sda at reset", 0, sda_oe);
      repeat (4) @(posedge clk);
      bad_addr({lmibs_pkg::DEV_TYPE, ~strap_hi, strap_lo, 1'b0});
      bad_addr({lmibs_pkg::DEV_TYPE, strap_hi, ~strap_lo, 1'b0});
      bad_addr({lmibs_pkg::DEV_TYPE ^ 5'h01, strap_hi, strap_lo, 1'b1});
      // no-op and illegal codes must leave the section alone
      foreach (codes[i]) begin
         wq = {codes[i]};
         wr(8'hFD);
         chk("section", sel_m, section);
      end
      for (int f = 0; f < 6; f++) begin
         wq = {8'(f + 1)};
         wr(8'hFD);
         // last frame runs one byte past its end, which must be dropped
         pf[f] = (f == 5) ? 177 : $urandom_range(176);
         wq = {8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom)};
         wr(8'(pf[f]));
         scan(f, pf[f]);
         rd(8'(pf[f]), 4);
         rd(8'hFD, 1);
      end
      u_master.slow = 20;
      wq = {8'h01};
      wr(8'hFD);
      rd(8'(pf[0]), 4);
      u_master.slow = 0;
      wq = {8'h0B};
      wr(8'hFD);
      wq = {8'h01};
      wr(8'h00);
      chk("layout", 1, layout);
      wq = {8'h00};
      wr(8'h0A);
      chk("shutdown cleared", 0, shutdown);
      rd(8'h00, 2);
      wq = {8'h01};
      wr(8'h0A);
      chk("shutdown set", 1, shutdown);
      wq = {8'h00};
      wr(8'h0A);
      @(posedge clk);
      hw_n <= 1'b0;
      repeat (5) @(posedge clk);
      @(negedge clk);
      chk("hw shutdown", 1, shutdown);
      chk("hw shutdown section", 8'h0B, section);
      @(posedge clk);
      hw_n <= 1'b1;
      m_reset();
      repeat (5) @(posedge clk);
      @(negedge clk);
      chk("shutdown reloaded", 1, shutdown);
      chk("layout reloaded", 0, layout);
      scan(3, pf[3]);
      rd(8'h0A, 1);
      final_report();
   end
endmodule
